// ---- fsk_pkg.sv ----
// Shared constants, types and register map for the formatted receive framer
// Summary of operation
// - Combined transfer: info in word 0 ending 110101, slow control in words 1-2.
// - Formatted receive splits calls into info, control, parameter and traffic blocks.
// - Word 0 bits 5-4 label transfer: 01 payload, 10 info, 11 control plus info.
// - Receive entry starts sync search; sync raises first/second detect, enables demodulator.
// - Check parity and CRC after sync; address match only on error-free control.
// - Accept call when user code is all-call or an own identifier and type passes, or when open receive is set.
// - Information type passes when its accept mask bit is set; default all pass.
// - Failed check with open receive clear rejects call, resumes sync search.
// - Acceptance raises called event, reports code and match type, starts transfers.
// - Sync-burst frame: send 36-bit call sign serial, ignore rest of frame.
// - Service frame: traffic blocks go to host or vocoder per communication mode.
// - Vocoder on for voice type, or other types when vocoder mask bit set.
// - Host speech and uncoded payload sent soft or hard per configuration bit.
// - Control and coded payload always hard, event on failure; vocoder always soft; here all blocks go soft when configuration bit 0 or vocoder is set.
// - Call end type disables vocoder, passes final fields, resumes sync search.
// - Second standard preamble only when configuration bit 11 set.
// - Frames begin with sync then radio info; mode and option pick processing.
// - Audio calls carry slow control every frame; start/end frames carry fast control.
// - User code and classification drive address matching and traffic routing.
// - Clearing classification ends call processing and disables the vocoder.
// - Control fields still reach host while traffic goes to vocoder.
// - First standard identifier 00 marks the parameter block with call sign serial.
package fsk_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_CFG      = 8'ha1;
  localparam logic [7:0] ADDR_TX0      = 8'hb5;
  localparam logic [7:0] ADDR_TX1      = 8'hb6;
  localparam logic [7:0] ADDR_TX2      = 8'hb7;
  localparam logic [7:0] ADDR_RX0      = 8'hb8;
  localparam logic [7:0] ADDR_RX1      = 8'hb9;
  localparam logic [7:0] ADDR_RX2      = 8'hba;
  localparam logic [7:0] ADDR_MODE     = 8'hc1;
  localparam logic [7:0] ADDR_AUX      = 8'hcc;
  localparam logic [7:0] ADDR_ID0      = 8'hd0;
  localparam logic [7:0] ADDR_ACC_MASK = 8'hd6;
  localparam logic [7:0] ADDR_VOC_MASK = 8'hd7;
  localparam int         NUM_IDS       = 6;
  // Mode and configuration
  localparam logic [15:0] MODE_FMT_RX  = 16'h0011;
  localparam int          CFG_SOFT     = 0;
  localparam int          CFG_OPEN_RX  = 1;
  localparam int          CFG_STD2     = 2;
  localparam int          CFG_PREAMBLE = 11;
  localparam logic [15:0] MASK_RESET   = 16'hffff;
  localparam logic [15:0] VOC_MASK_RST = 16'h0000;
  // Block identifiers and low word 0 bits
  localparam logic [1:0] ID_PARAM   = 2'h0;
  localparam logic [1:0] ID_PAYLOAD = 2'h1;
  localparam logic [1:0] ID_INFO    = 2'h2;
  localparam logic [1:0] ID_CTRL    = 2'h3;
  localparam logic [3:0] LOW_INFO   = 4'h1;
  localparam logic [3:0] LOW_CTRL   = 4'h5;
  localparam logic [3:0] LOW_PARAM  = 4'h5;
  localparam logic [3:0] LOW_PAY    = 4'h1;
  // Decoder block kinds
  localparam logic [1:0] KIND_CTRL  = 2'h0;
  localparam logic [1:0] KIND_PARAM = 2'h1;
  localparam logic [1:0] KIND_TCH   = 2'h2;
  localparam logic [1:0] KIND_INFO  = 2'h3;
  // Radio info and slow control fields
  localparam int         RI_STRUCT  = 6;
  localparam int         RI_CM_HI   = 5;
  localparam int         RI_CM_LO   = 4;
  localparam logic [1:0] CM_SPEECH  = 2'h0;
  localparam logic [1:0] CM_NS2     = 2'h2;
  localparam int         UC_HI      = 8;
  localparam int         IT_HI      = 12;
  localparam int         IT_LO      = 9;
  localparam logic [3:0] IT_VOICE   = 4'h1;
  localparam logic [3:0] IT_END     = 4'hf;
  localparam int         FIFO_DEPTH = 16;

  typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_HUNT, ST_CALL} fsk_state_t;

  typedef struct packed {
    logic [1:0]  kind;
    logic        crc_ok;
    logic [6:0]  ri;
    logic [35:0] data;
  } fsk_blk_t;

  typedef struct packed {
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] w2;
  } fsk_xfer_t;
endpackage : fsk_pkg

// ---- fsk_rx_framer.sv ----
// Formatted receive framer with host transfer buffer
`timescale 1ns/100ps

module fsk_fifo #(
  parameter int W = 48,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  // Fill side
  input  wire logic                 in_valid_in,
  output logic                      in_ready_out,
  input  wire logic [W-1:0]         in_data_in,
  // Drain side
  output logic                      out_valid_out,
  input  wire logic                 out_ready_in,
  output logic [W-1:0]              out_data_out,
  output logic [$clog2(D+1)-1:0]    count_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0]         mem_ff [D];
  logic [AW-1:0]        wp_ff;
  logic [AW-1:0]        rp_ff;
  logic [$clog2(D+1)-1:0] cnt_ff;
  logic                 push;
  logic                 pop;

  assign in_ready_out  = cnt_ff != D[$clog2(D+1)-1:0];
  assign out_valid_out = cnt_ff != '0;
  assign out_data_out  = mem_ff[rp_ff];
  assign count_out     = cnt_ff;
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wp_ff <= AW'(wp_ff + 1'b1);
      if (pop)
        rp_ff <= AW'(rp_ff + 1'b1);
      cnt_ff <= ($clog2(D+1))'(cnt_ff + push - pop);
    end
  end

  // Storage carries no reset, only pointers and count do
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_ff[wp_ff] <= in_data_in;
  end
endmodule : fsk_fifo

module fsk_rx_framer (
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  // Host register port
  input  wire logic [7:0]          reg_addr_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  input  wire logic [15:0]         reg_wdata_in,
  output logic [15:0]              reg_rdata_out,
  // Demodulator and decoder
  input  wire logic [1:0]          sync_det_in,
  input  wire logic                blk_valid_in,
  input  wire fsk_pkg::fsk_blk_t   blk_in,
  output logic                     blk_ready_out,
  output logic                     demod_en_out,
  output logic                     llr_mode_out,
  output logic                     preamble_en_out,
  // Event pulses to host
  output logic                     first_sync_detect_irq_out,
  output logic                     second_sync_detect_irq_out,
  output logic                     called_irq_out,
  output logic                     event_irq_out,
  output logic                     block_ready_irq_out,
  // Vocoder
  output logic                     vocoder_en_out,
  output logic                     voc_valid_out,
  output logic [35:0]              voc_data_out,
  // Transmit words to frame generator
  output logic                     tx_valid_out,
  output fsk_pkg::fsk_xfer_t       tx_block_words_out
);
  import fsk_pkg::*;

  typedef struct packed {
    fsk_state_t  state;
    logic [15:0] mode;
    logic [15:0] cfg;
    logic [NUM_IDS-1:0][8:0] own_id;
    logic [15:0] acc_mask;
    logic [15:0] voc_mask;
    logic [15:0] aux;
    fsk_xfer_t   rx_words;
    logic        rx_full;
    fsk_xfer_t   tx_words;
    logic        tx_valid;
    logic [1:0]  count;
    logic        sb_frame;
    logic [15:0] rdata;
    logic        blk_ready;
    logic        demod_en;
    logic        fs1_irq;
    logic        fs2_irq;
    logic        called_irq;
    logic        event_irq;
    logic        ready_irq;
    logic        voc_en;
    logic        voc_valid;
    logic [35:0] voc_data;
    logic        soft_likelihood_value;
    logic        preamble;
  } fsk_st_t;

  fsk_st_t   st_ff;
  fsk_st_t   nxt_st;
  fsk_xfer_t push_word;
  logic      push_en;
  logic      fifo_in_ready;
  logic      fifo_out_valid;
  logic      fifo_pop;
  fsk_xfer_t fifo_out;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_cnt;
  logic      take;

  function automatic logic [15:0] fsk_word0(input logic [6:0] ri, input logic [1:0] cnt,
                                            input logic [1:0] id, input logic [3:0] low);
    fsk_word0 = {1'b0, ri, cnt, id, low};
  endfunction : fsk_word0

  function automatic logic fsk_id_hit(input logic [8:0] uc, input fsk_st_t s);
    fsk_id_hit = 1'b0;
    for (int i = 0; i < NUM_IDS; i++)
      if (s.own_id[i] == uc)
        fsk_id_hit = 1'b1;
  endfunction : fsk_id_hit

  assign take     = blk_valid_in & st_ff.blk_ready;
  assign fifo_pop = fifo_out_valid & ~st_ff.rx_full;

  always_comb
  begin
    logic [8:0] uc;
    logic [3:0] it;
    logic       uc_ok;
    logic       it_ok;
    logic       ending;
    logic [1:0] cm;
    uc            = blk_in.data[UC_HI:0];
    it            = blk_in.data[IT_HI:IT_LO];
    uc_ok         = (uc == '0) || fsk_id_hit(uc, st_ff);
    it_ok         = st_ff.acc_mask[it];
    ending        = it == IT_END;
    cm            = blk_in.ri[RI_CM_HI:RI_CM_LO];
    nxt_st        = st_ff;
    push_en       = 1'b0;
    push_word     = '0;
    nxt_st.fs1_irq    = 1'b0;
    nxt_st.fs2_irq    = 1'b0;
    nxt_st.called_irq = 1'b0;
    nxt_st.event_irq  = 1'b0;
    nxt_st.ready_irq  = 1'b0;
    nxt_st.voc_valid  = 1'b0;
    nxt_st.tx_valid   = 1'b0;
    nxt_st.rdata      = '0;
    // Host reads
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        ADDR_CFG:      nxt_st.rdata = st_ff.cfg;
        ADDR_MODE:     nxt_st.rdata = st_ff.mode;
        ADDR_RX0:      nxt_st.rdata = st_ff.rx_words.w0;
        ADDR_RX1:      nxt_st.rdata = st_ff.rx_words.w1;
        ADDR_RX2:      nxt_st.rdata = st_ff.rx_words.w2;
        ADDR_AUX:      nxt_st.rdata = st_ff.aux;
        ADDR_ACC_MASK: nxt_st.rdata = st_ff.acc_mask;
        ADDR_VOC_MASK: nxt_st.rdata = st_ff.voc_mask;
        default:       nxt_st.rdata = '0;
      endcase
      if (reg_addr_in == ADDR_RX0)
        nxt_st.rx_full = 1'b0;
    end
    // Host writes
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        ADDR_CFG:      nxt_st.cfg = reg_wdata_in;
        ADDR_ACC_MASK: nxt_st.acc_mask = reg_wdata_in;
        ADDR_VOC_MASK: nxt_st.voc_mask = reg_wdata_in;
        ADDR_TX1:      nxt_st.tx_words.w1 = reg_wdata_in;
        ADDR_TX2:      nxt_st.tx_words.w2 = reg_wdata_in;
        ADDR_TX0:
        begin
          // Reserved identifier leaves frame generation untouched
          if (!(st_ff.cfg[CFG_STD2] && reg_wdata_in[5:4] == ID_PARAM))
          begin
            nxt_st.tx_words.w0 = reg_wdata_in;
            nxt_st.tx_valid    = 1'b1;
          end
        end
        ADDR_MODE:
        begin
          nxt_st.mode   = reg_wdata_in;
          nxt_st.voc_en = 1'b0;
          nxt_st.state  = (reg_wdata_in == MODE_FMT_RX) ? ST_SEARCH : ST_IDLE;
          nxt_st.demod_en = 1'b0;
        end
        default:
        begin
          for (int i = 0; i < NUM_IDS; i++)
            if (reg_addr_in == ADDR_ID0 + 8'(i))
              nxt_st.own_id[i] = reg_wdata_in[8:0];
        end
      endcase
    end
    // Receive sequencing
    if (!(reg_wr_in && reg_addr_in == ADDR_MODE))
    begin
      case (st_ff.state)
        ST_IDLE: nxt_st.demod_en = 1'b0;
        ST_SEARCH:
        begin
          nxt_st.demod_en = 1'b0;
          if (sync_det_in != 2'b00)
          begin
            nxt_st.fs1_irq  = sync_det_in[0];
            nxt_st.fs2_irq  = ~sync_det_in[0];
            nxt_st.demod_en = 1'b1;
            nxt_st.state    = ST_HUNT;
          end
        end
        ST_HUNT:
        begin
          // Matching waits for a clean control block; bad ones keep scanning
          if (take && blk_in.kind == KIND_CTRL)
          begin
            if (!blk_in.crc_ok)
              nxt_st.event_irq = 1'b1;
            else if ((uc_ok && it_ok) || st_ff.cfg[CFG_OPEN_RX])
            begin
              nxt_st.called_irq = 1'b1;
              nxt_st.aux        = {6'h0, uc == '0, uc};
              nxt_st.state      = ST_CALL;
              nxt_st.sb_frame   = blk_in.ri[RI_STRUCT];
              nxt_st.voc_en     = cm == CM_SPEECH
                                  && (it == IT_VOICE || st_ff.voc_mask[it]);
              push_en           = 1'b1;
            end
            else
            begin
              nxt_st.state    = ST_SEARCH;
              nxt_st.demod_en = 1'b0;
            end
          end
        end
        ST_CALL:
        begin
          if (take)
          begin
            case (blk_in.kind)
              KIND_CTRL:
              begin
                push_en          = 1'b1;
                nxt_st.event_irq = ~blk_in.crc_ok;
                nxt_st.sb_frame  = blk_in.ri[RI_STRUCT];
                if (blk_in.crc_ok && ending)
                begin
                  nxt_st.voc_en   = 1'b0;
                  nxt_st.state    = ST_SEARCH;
                  nxt_st.demod_en = 1'b0;
                end
              end
              KIND_INFO:
              begin
                push_en          = 1'b1;
                nxt_st.event_irq = ~blk_in.crc_ok;
                nxt_st.sb_frame  = blk_in.ri[RI_STRUCT];
              end
              KIND_PARAM:
              begin
                if (st_ff.sb_frame && !st_ff.cfg[CFG_STD2])
                  push_en = 1'b1;
              end
              KIND_TCH:
              begin
                // Traffic of a sync-burst frame is padding and dropped
                if (!st_ff.sb_frame)
                begin
                  if (st_ff.voc_en && cm == CM_SPEECH)
                  begin
                    nxt_st.voc_valid = 1'b1;
                    nxt_st.voc_data  = blk_in.data;
                  end
                  else
                  begin
                    push_en          = 1'b1;
                    nxt_st.event_irq = (cm == CM_NS2) && !blk_in.crc_ok;
                  end
                end
              end
              default: push_en = 1'b0;
            endcase
          end
        end
        default: nxt_st.state = ST_IDLE;
      endcase
    end
    // Word building for the host
    if (push_en)
    begin
      case (blk_in.kind)
        KIND_CTRL: push_word = '{fsk_word0(blk_in.ri, st_ff.count, ID_CTRL, LOW_CTRL),
                                 blk_in.data[15:0],
                                 {blk_in.data[23:16], 6'h0, blk_in.data[25:24]}};
        KIND_INFO: push_word = '{fsk_word0(blk_in.ri, st_ff.count, ID_INFO, LOW_INFO),
                                 16'h0, 16'h0};
        KIND_PARAM: push_word = '{{blk_in.data[27:24], blk_in.data[31:28], st_ff.count,
                                   ID_PARAM, LOW_PARAM},
                                  {blk_in.data[35:32], blk_in.data[15:12],
                                   blk_in.data[19:16], blk_in.data[23:20]},
                                  {blk_in.data[3:0], blk_in.data[7:4], 4'h0,
                                   blk_in.data[11:8]}};
        default:  push_word = '{fsk_word0(blk_in.ri, st_ff.count, ID_PAYLOAD, LOW_PAY),
                                blk_in.data[31:16], blk_in.data[15:0]};
      endcase
      nxt_st.count = 2'(st_ff.count + 1'b1);
    end
    if (fifo_pop)
    begin
      nxt_st.rx_words  = fifo_out;
      nxt_st.rx_full   = 1'b1;
      nxt_st.ready_irq = 1'b1;
    end
    // Ready follows the next state, so no block is taken into a search
    nxt_st.blk_ready = (fifo_cnt < ($clog2(FIFO_DEPTH+1))'(FIFO_DEPTH - 1))
                       && (nxt_st.state == ST_HUNT || nxt_st.state == ST_CALL);
    nxt_st.soft_likelihood_value       = nxt_st.cfg[CFG_SOFT] | nxt_st.voc_en;
    nxt_st.preamble  = nxt_st.cfg[CFG_STD2] & nxt_st.cfg[CFG_PREAMBLE];
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_ff          <= '0;
      st_ff.state    <= ST_IDLE;
      st_ff.acc_mask <= MASK_RESET;
      st_ff.voc_mask <= VOC_MASK_RST;
    end
    else
      st_ff <= nxt_st;
  end

  fsk_fifo #(.W($bits(fsk_xfer_t)), .D(FIFO_DEPTH)) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (push_en),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (push_word),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (~st_ff.rx_full),
    .out_data_out  (fifo_out),
    .count_out     (fifo_cnt)
  );

  assign reg_rdata_out              = st_ff.rdata;
  assign blk_ready_out              = st_ff.blk_ready;
  assign demod_en_out               = st_ff.demod_en;
  assign llr_mode_out               = st_ff.soft_likelihood_value;
  assign preamble_en_out            = st_ff.preamble;
  assign first_sync_detect_irq_out  = st_ff.fs1_irq;
  assign second_sync_detect_irq_out = st_ff.fs2_irq;
  assign called_irq_out             = st_ff.called_irq;
  assign event_irq_out              = st_ff.event_irq;
  assign block_ready_irq_out        = st_ff.ready_irq;
  assign vocoder_en_out             = st_ff.voc_en;
  assign voc_valid_out              = st_ff.voc_valid;
  assign voc_data_out               = st_ff.voc_data;
  assign tx_valid_out               = st_ff.tx_valid;
  assign tx_block_words_out         = st_ff.tx_words;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_sync_enables: assert property ((st_ff.state == ST_SEARCH && sync_det_in != 2'b00 && !reg_wr_in)
    |=> demod_en_out && (first_sync_detect_irq_out || second_sync_detect_irq_out))
    else $error("sync detect did not enable demodulator");
  a_bad_ctrl_hold: assert property ((st_ff.state == ST_HUNT && take && blk_in.kind == KIND_CTRL
    && !blk_in.crc_ok && !reg_wr_in) |=> st_ff.state == ST_HUNT && event_irq_out
    && !called_irq_out)
    else $error("bad control block was matched");
  a_call_accept: assert property ((st_ff.state == ST_HUNT && take && blk_in.kind == KIND_CTRL
    && blk_in.crc_ok && blk_in.data[UC_HI:0] == '0 && !reg_wr_in
    && st_ff.acc_mask[blk_in.data[IT_HI:IT_LO]])
    |=> called_irq_out && st_ff.state == ST_CALL && st_ff.aux[9])
    else $error("all-call not accepted");
  a_reject_resume: assert property ((st_ff.state == ST_HUNT && take && blk_in.kind == KIND_CTRL
    && blk_in.crc_ok && !st_ff.acc_mask[blk_in.data[IT_HI:IT_LO]] && !st_ff.cfg[CFG_OPEN_RX]
    && !reg_wr_in) |=> st_ff.state == ST_SEARCH && !called_irq_out)
    else $error("masked type not rejected");
  a_end_stops: assert property ((st_ff.state == ST_CALL && take && blk_in.kind == KIND_CTRL
    && blk_in.crc_ok && blk_in.data[IT_HI:IT_LO] == IT_END && !reg_wr_in)
    |=> !vocoder_en_out && st_ff.state == ST_SEARCH && !demod_en_out)
    else $error("call end not handled");
  a_ctrl_word: assert property ((push_en && blk_in.kind == KIND_CTRL)
    |-> push_word.w0[5:0] == 6'h35 && push_word.w0[15] == 1'b0)
    else $error("control word 0 malformed");
  a_info_word: assert property ((push_en && blk_in.kind == KIND_INFO)
    |-> push_word.w0[5:0] == 6'h21 && push_word.w1 == '0)
    else $error("info word 0 malformed");
  a_voc_soft: assert property (voc_valid_out |-> vocoder_en_out && llr_mode_out)
    else $error("vocoder data not soft");
  a_ready_load: assert property ($rose(st_ff.rx_full) |-> block_ready_irq_out
    ##1 !block_ready_irq_out)
    else $error("ready event not single pulse");
  a_tx_reserved: assert property ((reg_wr_in && reg_addr_in == ADDR_TX0 && st_ff.cfg[CFG_STD2]
    && reg_wdata_in[5:4] == ID_PARAM) |=> !tx_valid_out)
    else $error("reserved identifier accepted");

  c_call: cover property (st_ff.state == ST_HUNT ##1 called_irq_out);
  c_end: cover property (st_ff.state == ST_CALL ##1 st_ff.state == ST_SEARCH);
  c_voc: cover property (voc_valid_out);
  c_fifo_full: cover property (!fifo_in_ready);
endmodule : fsk_rx_framer

// ---- fsk_host_model.sv ----
// Host model: register master that services block-ready events
`timescale 1ns/100ps
module fsk_host_model (
  // Clock
  input  wire logic        clk_in,
  // Register port
  output logic [7:0]       addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic [15:0]      wdata_out,
  input  wire logic [15:0] rdata_in
);
  initial {addr_out, wr_out, rd_out, wdata_out} = '0;
  // One-cycle strobe; data inverted afterwards so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_in);
    {addr_out, wdata_out, wr_out} = {a, d, 1'b1};
    @(negedge clk_in);
    {wr_out, wdata_out} = {1'b0, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk_in);
    {addr_out, rd_out} = {a, 1'b1};
    @(negedge clk_in);
    rd_out = 1'b0;
    d = rdata_in;
  endtask : rd
  // Word 0 last: reading it frees the words for the next block
  task automatic get_blk(output logic [47:0] w);
    rd(fsk_pkg::ADDR_RX1, w[31:16]);
    rd(fsk_pkg::ADDR_RX2, w[15:0]);
    rd(fsk_pkg::ADDR_RX0, w[47:32]);
  endtask : get_blk
endmodule : fsk_host_model

// ---- tb_fsk_rx_framer.sv ----
// Self-checking bench for the formatted receive framer
`timescale 1ns/100ps
module tb_fsk_rx_framer;
  import fsk_pkg::*;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, blk_valid_in = 1'b0, reg_wr_in, reg_rd_in;
  logic [1:0]  sync_det_in = 2'h0;
  logic [7:0]  reg_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out, r;
  fsk_blk_t    blk_in = '0;
  logic        blk_ready_out, demod_en_out, llr_mode_out, preamble_en_out, vocoder_en_out;
  logic        voc_valid_out, tx_valid_out, called_irq_out, event_irq_out, block_ready_irq_out;
  logic        first_sync_detect_irq_out, second_sync_detect_irq_out;
  logic [35:0] voc_data_out, vd, d, t;
  fsk_xfer_t   tx_block_words_out, tw;
  logic [6:0]  ri;
  logic [47:0] exq[$];
  int          n_errors = 0, checks_done = 0, cnt = 0, k = 0;
  int          nf1 = 0, nf2 = 0, ncl = 0, nev = 0, nrd = 0, nvo = 0, ntx = 0;

  always #12.5 clk_in = ~clk_in;
  fsk_host_model host (.clk_in, .addr_out(reg_addr_in), .wr_out(reg_wr_in),
    .rd_out(reg_rd_in), .wdata_out(reg_wdata_in), .rdata_in(reg_rdata_out));
  fsk_rx_framer dut (.clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
    .reg_rdata_out, .sync_det_in, .blk_valid_in, .blk_in, .blk_ready_out, .demod_en_out,
    .llr_mode_out, .preamble_en_out, .first_sync_detect_irq_out, .second_sync_detect_irq_out,
    .called_irq_out, .event_irq_out, .block_ready_irq_out, .vocoder_en_out, .voc_valid_out,
    .voc_data_out, .tx_valid_out, .tx_block_words_out);

  // Pulses are one cycle wide, so they are counted on every rising edge
  always @(posedge clk_in)
  begin
    nf1 += first_sync_detect_irq_out;
    nf2 += second_sync_detect_irq_out;
    ncl += called_irq_out;
    nev += event_irq_out;
    nrd += block_ready_irq_out;
    nvo += voc_valid_out;
    ntx += tx_valid_out;
    if (voc_valid_out === 1'b1)
      vd = voc_data_out;
    if (tx_valid_out === 1'b1)
      tw = tx_block_words_out;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic fail();
    n_errors++;
    finish_test();
  endtask : fail
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  task automatic waitc(ref int c, input int v);
    for (int i = 0; i < 60 && c < v; i++) @(negedge clk_in);
    if (c < v)
      fail();
  endtask : waitc
  task automatic offer(logic [1:0] kd, logic ok, logic [6:0] ri, logic [35:0] d);
    int i;
    @(negedge clk_in);
    blk_in = '{kd, ok, ri, d};
    blk_valid_in = 1'b1;
    for (i = 0; i < 60 && blk_ready_out !== 1'b1; i++) @(negedge clk_in);
    if (i == 60)
      fail();
    @(negedge clk_in);
    blk_valid_in = 1'b0;
    blk_in = ~blk_in;
  endtask : offer
  task automatic sync(logic [1:0] s);
    @(negedge clk_in) sync_det_in = s;
    @(negedge clk_in) sync_det_in = 2'h0;
  endtask : sync
  // Expected host words for one pushed block
  function automatic void push(logic [1:0] id, logic [3:0] lo, logic [35:0] d);
    exq.push_back({1'b0, ri, cnt[1:0], id, lo, d[15:0], d[23:16], 6'h0, d[25:24]});
    cnt++;
  endfunction : push
  task automatic take(input bit full);
    logic [47:0] w;
    logic [47:0] e;
    k++;
    waitc(nrd, k);
    host.get_blk(w);
    e = exq.pop_front();
    if (!full)
      w[31:0] = e[31:0];
    chk("rx_words", e, w);
  endtask : take

  initial
  begin
    void'($urandom(32'h8c65));
    repeat (20) @(posedge clk_in);
    @(negedge clk_in) rst_n_in = 1'b1;
    host.rd(8'h00, r);
    chk("unmapped", 0, r);
    host.wr(ADDR_MODE, MODE_FMT_RX);
    sync(2'b01);
    waitc(nf1, 1);
    chk("demod_on", 1, demod_en_out);
    ri = {3'b000, 4'($urandom)};
    d = {10'h0, 13'($urandom), IT_VOICE, 9'h0};
    offer(KIND_CTRL, 1'b1, ri, d);
    push(ID_CTRL, LOW_CTRL, d);
    waitc(ncl, 1);
    take(1'b1);
    host.rd(ADDR_AUX, r);
    chk("aux", {6'h0, 1'b1, 9'h0}, r);
    chk("voc_on", 2'b11, {vocoder_en_out, llr_mode_out});
    t = 36'($urandom);
    offer(KIND_TCH, 1'b1, ri, t);
    waitc(nvo, 1);
    chk("voc_data", t, vd);
    offer(KIND_INFO, 1'b1, ri, 36'h0);
    push(ID_INFO, LOW_INFO, 36'h0);
    take(1'b0);
    d[12:9] = IT_END;
    offer(KIND_CTRL, 1'b1, ri, d);
    push(ID_CTRL, LOW_CTRL, d);
    take(1'b1);
    chk("end_state", 0, {vocoder_en_out, demod_en_out, llr_mode_out});
    host.wr(ADDR_ACC_MASK, 16'hfffd);
    sync(2'b10);
    waitc(nf2, 1);
    d[12:9] = IT_VOICE;
    offer(KIND_CTRL, 1'b1, ri, d);
    repeat (6) @(negedge clk_in);
    chk("reject", {32'd1, 1'b0}, {ncl, demod_en_out});
    sync(2'b01);
    offer(KIND_CTRL, 1'b0, ri, d);
    waitc(nev, 1);
    ri = {1'b1, CM_SPEECH, 4'($urandom)};
    d = {10'h0, 13'($urandom), 4'h2, 9'h1a5};
    host.wr(ADDR_ID0 + 8'h3, 16'h01a5);
    offer(KIND_CTRL, 1'b1, ri, d);
    push(ID_CTRL, LOW_CTRL, d);
    waitc(ncl, 2);
    take(1'b1);
    host.rd(ADDR_AUX, r);
    chk("aux_own", 16'h01a5, r);
    t = {4'($urandom), 32'($urandom)};
    offer(KIND_PARAM, 1'b1, ri, t);
    exq.push_back({t[27:24], t[31:28], cnt[1:0], ID_PARAM, LOW_PARAM, t[35:32], t[15:12],
      t[19:16], t[23:20], t[3:0], t[7:4], 4'h0, t[11:8]});
    cnt++;
    take(1'b1);
    offer(KIND_TCH, 1'b1, ri, t);
    repeat (6) @(negedge clk_in);
    chk("burst_drop", 5, nrd);
    ri = {1'b0, CM_NS2, 4'($urandom)};
    offer(KIND_CTRL, 1'b1, ri, d);
    push(ID_CTRL, LOW_CTRL, d);
    take(1'b1);
    offer(KIND_TCH, 1'b0, ri, t);
    exq.push_back({1'b0, ri, cnt[1:0], ID_PAYLOAD, LOW_PAY, t[31:0]});
    cnt++;
    take(1'b1);
    chk("ns2_event", 2, nev);
    host.wr(ADDR_TX1, d[15:0]);
    host.wr(ADDR_TX2, t[15:0]);
    host.wr(ADDR_TX0, {1'b0, ri, 2'b00, ID_INFO, LOW_INFO});
    waitc(ntx, 1);
    chk("tx_words", {1'b0, ri, 2'b00, ID_INFO, LOW_INFO, d[15:0], t[15:0]}, tw);
    host.wr(ADDR_CFG, 16'h0800);
    chk("cfg_off", 0, {preamble_en_out, llr_mode_out});
    host.wr(ADDR_CFG, 16'h0805);
    chk("cfg_on", 2'b11, {preamble_en_out, llr_mode_out});
    host.wr(ADDR_TX0, {1'b0, ri, 2'b00, ID_PARAM, LOW_INFO});
    repeat (6) @(negedge clk_in);
    chk("tx_reserved", 1, ntx);
    finish_test();
  end
endmodule : tb_fsk_rx_framer
